// file: bus_info_pkg.sv
// Package with register map, field layout and reset values of the bus info block
package bus_info_pkg;
  // Register byte offsets
  localparam logic [5:0] OFF_HEADER = 6'h00;
  localparam logic [5:0] OFF_NAME = 6'h04;
  localparam logic [5:0] OFF_OPTIONS = 6'h08;
  localparam logic [5:0] OFF_ID_HIGH = 6'h0C;
  localparam logic [5:0] OFF_ID_LOW = 6'h10;
  localparam logic [5:0] OFF_CONTROL = 6'h14;
  localparam logic [5:0] OFF_ROM_PORT = 6'h18;
  // Quadlet indices on the remote read port
  localparam logic [2:0] Q_HEADER = 3'h0;
  localparam logic [2:0] Q_NAME = 3'h1;
  localparam logic [2:0] Q_OPTIONS = 3'h2;
  localparam logic [2:0] Q_ID_HIGH = 3'h3;
  localparam logic [2:0] Q_ID_LOW = 3'h4;
  // Constant bus name, ASCII "1394"
  localparam logic [31:0] BUS_NAME_VALUE = 32'h31333934;
  // Bus options field positions
  localparam int SPD_LSB = 0;
  localparam int SPD_W = 3;
  localparam int REV_LSB = 6;
  localparam int REV_W = 2;
  localparam int PAYLOAD_LSB = 12;
  localparam int PAYLOAD_W = 4;
  localparam int ACC_LSB = 16;
  localparam int CAP_LSB = 27;
  // Writable bits of the options word (all 32)
  localparam logic [31:0] OPTIONS_WMASK = 32'hFFFFFFFF;
  // Hard reset values
  localparam logic [31:0] HEADER_RESET = 32'h00000000;
  localparam logic [31:0] ID_RESET = 32'h00000000;
  localparam logic [31:0] OPTIONS_RESET = 32'h00000000;
  // Control register bits
  localparam int CTL_LINK_BIT = 0;
  localparam int CTL_SOFT_BIT = 1;
  localparam int CTL_LOCK_BIT = 2;
  // Payload code 8 means 2^(8+1) = 512 bytes
  localparam logic [3:0] PAYLOAD_MIN = 4'h8;
endpackage

// file: bus_info_block_regs.sv
// Bus info block registers served to remote nodes and written by the host
`timescale 1ns/1ps

module bus_info_block_regs
  import bus_info_pkg::*;
#(
  parameter logic [3:0] MAX_PAYLOAD_CODE = PAYLOAD_MIN,
  parameter logic [2:0] MAX_SPEED_CODE = 3'h2,
  parameter logic [12:0] PAYLOAD_BYTES_MAX = 13'h0200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  input wire logic rom_req,
  input wire logic [2:0] rom_quadlet,
  output logic [31:0] rom_data,
  output logic rom_valid,
  input wire logic pkt_check,
  input wire logic pkt_block_write,
  input wire logic [15:0] pkt_length,
  input wire logic [2:0] pkt_speed,
  output logic pkt_reject,
  output logic pkt_type_error,
  output logic pkt_done,
  output logic link_active_ctl
);

  // Idle code is 1 so that waitrequest is the state flop itself
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b1,
    BUS_ANSWER = 1'b0
  } bus_state_t;

  typedef struct packed {
    bus_state_t st;
    logic [31:0] header;
    logic [31:0] options;
    logic [31:0] id_high;
    logic [31:0] id_low;
    logic id_high_set;
    logic id_low_set;
    logic id_locked;
    logic link_active;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic [31:0] rom_data;
    logic rom_valid;
    logic reject;
    logic type_error;
    logic done;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [31:0] mask;
  logic [31:0] wmerged;
  logic soft_rst;
  logic [16:0] payload_bytes;
  logic rd_hit;

  // ----------------------------------------------------------------
  // Combinational next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
            {8{byteenable[1]}}, {8{byteenable[0]}}};
    wmerged = 32'h00000000;
    soft_rst = 1'b0;
    rd_hit = 1'b1;
    payload_bytes = 17'h00000;
    s_d.rom_valid = 1'b0;
    s_d.done = 1'b0;
    s_d.reject = 1'b0;
    s_d.type_error = 1'b0;
    unique case (s_q.st)
      BUS_IDLE: begin
        if (read || write) begin
          s_d.st = BUS_ANSWER;
          s_d.resp = 2'h0;
          s_d.rdata = 32'h00000000;
        end
        if (write) begin
          unique case (address)
            OFF_HEADER: begin
              s_d.header = (s_q.header & ~mask) | (writedata & mask);
            end
            OFF_OPTIONS: begin
              // Reserved ranges are kept as ordinary storage
              wmerged = mask & OPTIONS_WMASK;
              s_d.options = (s_q.options & ~wmerged) |
                            (writedata & wmerged);
              // Speed may be set to any code up to capability, never above it
              if (writedata[SPD_LSB +: SPD_W] > MAX_SPEED_CODE) begin
                s_d.options[SPD_LSB +: SPD_W] = MAX_SPEED_CODE;
              end
            end
            OFF_ID_HIGH: begin
              if (!s_q.id_locked && !s_q.id_high_set) begin
                s_d.id_high = writedata;
                s_d.id_high_set = 1'b1;
              end
            end
            OFF_ID_LOW: begin
              if (!s_q.id_locked && !s_q.id_low_set) begin
                s_d.id_low = writedata;
                s_d.id_low_set = 1'b1;
              end
            end
            OFF_CONTROL: begin
              s_d.link_active = writedata[CTL_LINK_BIT];
              soft_rst = writedata[CTL_SOFT_BIT];
            end
            OFF_ROM_PORT: begin
              // Autonomous ROM load: both halves in one go, only once
              if (!s_q.id_locked && !s_q.id_high_set && !s_q.id_low_set) begin
                s_d.id_high = writedata;
                s_d.id_low = ~writedata;
                s_d.id_locked = 1'b1;
              end
            end
            OFF_NAME: begin
            end
            default: begin
              s_d.resp = 2'h2;
            end
          endcase
        end else if (read) begin
          unique case (address)
            OFF_HEADER: s_d.rdata = s_q.header;
            OFF_NAME: s_d.rdata = BUS_NAME_VALUE;
            OFF_OPTIONS: s_d.rdata = s_q.options;
            OFF_ID_HIGH: s_d.rdata = s_q.id_high;
            OFF_ID_LOW: s_d.rdata = s_q.id_low;
            OFF_CONTROL: begin
              s_d.rdata[CTL_LINK_BIT] = s_q.link_active;
              s_d.rdata[CTL_LOCK_BIT] = s_q.id_locked;
            end
            OFF_ROM_PORT: s_d.rdata = 32'h00000000;
            default: rd_hit = 1'b0;
          endcase
          if (!rd_hit) begin
            s_d.resp = 2'h2;
          end
        end
      end
      BUS_ANSWER: begin
        s_d.st = BUS_IDLE;
      end
    endcase
    // Both halves written by firmware closes the load path
    if (s_d.id_high_set && s_d.id_low_set) begin
      s_d.id_locked = 1'b1;
    end
    // Soft reset: header, identity and payload keep their values
    if (soft_rst) begin
      s_d.link_active = 1'b0;
      s_d.options[SPD_LSB +: SPD_W] = MAX_SPEED_CODE;
    end
    // Remote quadlet reads of the first five ROM quadlets
    if (rom_req) begin
      s_d.rom_valid = 1'b1;
      unique case (rom_quadlet)
        Q_HEADER: s_d.rom_data = s_q.header;
        Q_NAME: s_d.rom_data = BUS_NAME_VALUE;
        Q_OPTIONS: s_d.rom_data = s_q.options;
        Q_ID_HIGH: s_d.rom_data = s_q.id_high;
        Q_ID_LOW: s_d.rom_data = s_q.id_low;
        default: s_d.rom_data = 32'h00000000;
      endcase
    end
    // Incoming packet screening
    if (pkt_check) begin
      s_d.done = 1'b1;
      // Wide enough for every payload code, so large codes never wrap
      payload_bytes = 17'h00002 << s_q.options[PAYLOAD_LSB +: PAYLOAD_W];
      s_d.reject = pkt_speed > s_q.options[SPD_LSB +: SPD_W];
      s_d.type_error = pkt_block_write &&
                       ({1'b0, pkt_length} > payload_bytes);
    end
    if (rst) begin
      s_d = '0;
      s_d.st = BUS_IDLE;
      s_d.header = HEADER_RESET;
      s_d.id_high = ID_RESET;
      s_d.id_low = ID_RESET;
      s_d.options = OPTIONS_RESET;
      s_d.options[PAYLOAD_LSB +: PAYLOAD_W] = MAX_PAYLOAD_CODE;
      s_d.options[SPD_LSB +: SPD_W] = MAX_SPEED_CODE;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (clk_en || rst) begin
      s_q <= s_d;
    end
  end

  assign readdata = s_q.rdata;
  assign waitrequest = s_q.st;
  assign response = s_q.resp;
  assign rom_data = s_q.rom_data;
  assign rom_valid = s_q.rom_valid;
  assign pkt_reject = s_q.reject;
  assign pkt_type_error = s_q.type_error;
  assign pkt_done = s_q.done;
  assign link_active_ctl = s_q.link_active;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Writes act at the edge where the idle slave takes the request
  sequence bus_take_s;
    (read || write) && clk_en && waitrequest;
  endsequence

  sequence id_write_s;
    write && clk_en && waitrequest && s_q.id_locked &&
      (address == OFF_ID_HIGH || address == OFF_ID_LOW);
  endsequence

  sequence soft_write_s;
    write && clk_en && waitrequest && (address == OFF_CONTROL) &&
      writedata[CTL_SOFT_BIT];
  endsequence

  sequence rom_load_s;
    write && clk_en && waitrequest && (address == OFF_ROM_PORT) &&
      !s_q.id_locked && !s_q.id_high_set && !s_q.id_low_set;
  endsequence

  hdr_reset_a: assert property (@(posedge clk)
    rst |=> s_q.header == 32'h00000000)
    else $error("header not cleared by reset");
  name_fixed_a: assert property (@(posedge clk)
    disable iff (rst)
    rom_req && rom_quadlet == Q_NAME && clk_en |=>
      rom_data == 32'h31333934)
    else $error("bus name quadlet wrong");
  name_read_a: assert property (@(posedge clk)
    disable iff (rst)
    read && clk_en && waitrequest && address == OFF_NAME |=>
      readdata == 32'h31333934)
    else $error("bus name register wrong");
  opt_remote_a: assert property (@(posedge clk)
    disable iff (rst)
    rom_req && rom_quadlet == Q_OPTIONS && clk_en |=>
      rom_data == $past(s_q.options))
    else $error("options quadlet mismatch");
  payload_reset_a: assert property (@(posedge clk)
    rst |=> s_q.options[PAYLOAD_LSB +: PAYLOAD_W] == MAX_PAYLOAD_CODE)
    else $error("payload code not loaded at reset");
  payload_floor_a: assert property (@(posedge clk)
    rst |=> (17'h00002 << s_q.options[PAYLOAD_LSB +: PAYLOAD_W]) >=
      {4'h0, PAYLOAD_BYTES_MAX})
    else $error("reset payload below the floor");
  soft_keep_a: assert property (@(posedge clk)
    disable iff (rst)
    soft_write_s |=> s_q.options[PAYLOAD_LSB +: PAYLOAD_W] ==
      $past(s_q.options[PAYLOAD_LSB +: PAYLOAD_W]))
    else $error("soft reset changed payload code");
  speed_reset_a: assert property (@(posedge clk)
    rst |=> s_q.options[SPD_LSB +: SPD_W] == MAX_SPEED_CODE)
    else $error("speed code not loaded at reset");
  speed_reject_a: assert property (@(posedge clk)
    disable iff (rst)
    pkt_check && clk_en && pkt_speed > s_q.options[SPD_LSB +: SPD_W]
      |=> pkt_reject)
    else $error("fast packet not rejected");
  id_reset_a: assert property (@(posedge clk)
    rst |=> s_q.id_high == 32'h0 && s_q.id_low == 32'h0)
    else $error("identity not cleared");
  id_soft_a: assert property (@(posedge clk)
    disable iff (rst)
    soft_write_s |=> $stable(s_q.id_high) && $stable(s_q.id_low))
    else $error("soft reset changed identity");
  id_lock_a: assert property (@(posedge clk)
    disable iff (rst)
    id_write_s |=> $stable(s_q.id_high) && $stable(s_q.id_low))
    else $error("locked identity changed");
  rom_lock_a: assert property (@(posedge clk)
    disable iff (rst)
    rom_load_s |=> s_q.id_locked)
    else $error("identity not locked after load");
  id_keep_a: assert property (@(posedge clk)
    disable iff (rst)
    s_q.id_locked |=> s_q.id_locked)
    else $error("identity lock released");
  pay_err_a: assert property (@(posedge clk)
    disable iff (rst)
    pkt_check && clk_en && !pkt_block_write |=> !pkt_type_error)
    else $error("type error on non block write");
  bus_wait_a: assert property (@(posedge clk)
    disable iff (rst)
    bus_take_s |=> !waitrequest)
    else $error("bus answer not one cycle after request");
  bus_end_a: assert property (@(posedge clk)
    disable iff (rst)
    !waitrequest && clk_en |=> waitrequest)
    else $error("bus answer held too long");
endmodule

// file: remote_node.sv
// Remote node model that reads bus info block quadlets over the ROM port
`timescale 1ns/1ps
module remote_node (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [2:0] idx,
  input wire logic [31:0] rom_data,
  input wire logic rom_valid,
  output logic rom_req,
  output logic [2:0] rom_quadlet,
  output logic [31:0] quad,
  output logic got
);
  // Index scrambles outside a request so a stale value never passes
  always_ff @(posedge clk) begin
    rom_req <= start & ~rst;
    rom_quadlet <= start ? idx : (rst ? 3'h0 : ~rom_quadlet);
    got <= rom_valid & ~rst;
    if (rom_valid) begin
      quad <= rom_data;
    end
  end
endmodule

// file: bus_info_block_regs_test.sv
// Self-checking testbench of the bus info block registers
`timescale 1ns/1ps
module bus_info_block_regs_test;
  import bus_info_pkg::*;
  logic clk, rst, read, write, rom_req, rom_valid, pkt_check, pkt_bw;
  logic waitrequest, pkt_reject, pkt_type_error, pkt_done, link_on;
  logic start, got;
  logic [5:0] address;
  logic [31:0] writedata, readdata, rom_data, quad, d;
  logic [1:0] response, r;
  logic [2:0] rom_quadlet, idx, pkt_speed;
  logic [15:0] pkt_length;
  logic [3:0] be;
  int errors = 0;
  int num_checks = 0;

  bus_info_block_regs uut (.clk(clk), .rst(rst), .clk_en(1'b1),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(be), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .rom_req(rom_req),
    .rom_quadlet(rom_quadlet), .rom_data(rom_data),
    .rom_valid(rom_valid), .pkt_check(pkt_check),
    .pkt_block_write(pkt_bw), .pkt_length(pkt_length),
    .pkt_speed(pkt_speed), .pkt_reject(pkt_reject),
    .pkt_type_error(pkt_type_error), .pkt_done(pkt_done),
    .link_active_ctl(link_on));
  remote_node far (.clk(clk), .rst(rst), .start(start), .idx(idx),
    .rom_data(rom_data), .rom_valid(rom_valid), .rom_req(rom_req),
    .rom_quadlet(rom_quadlet), .quad(quad), .got(got));

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request holds until waitrequest is sampled low at a rising edge
  task automatic bus(logic wr, logic [5:0] a, logic [31:0] w);
    @(posedge clk);
    address <= a;
    writedata <= w;
    read <= ~wr;
    write <= wr;
    // Only the watchdog ends a wait that never sees an answer
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    d = readdata;
    r = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(string nm, logic [5:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(nm, e, d);
  endtask
  task automatic rom(logic [2:0] q, logic [31:0] e);
    @(posedge clk);
    start <= 1'b1;
    idx <= q;
    @(posedge clk);
    start <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      #1;
      if (got === 1'b1) break;
    end
    chk("rom quadlet", e, (got === 1'b1) ? quad : ~e);
  endtask
  task automatic pkt(logic bw, logic [15:0] len, logic [2:0] s,
                     logic rj, logic te);
    @(posedge clk);
    pkt_check <= 1'b1;
    pkt_bw <= bw;
    pkt_length <= len;
    pkt_speed <= s;
    @(posedge clk);
    pkt_check <= 1'b0;
    #1;
    chk("pkt flags", {29'h0, 1'b1, rj, te},
        {29'h0, pkt_done, pkt_reject, pkt_type_error});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd("header", OFF_HEADER, 32'h00000000);
    rd("name", OFF_NAME, 32'h31333934);
    rd("options", OFF_OPTIONS, 32'h00008002);
    rd("id high", OFF_ID_HIGH, 32'h00000000);
    rd("id low", OFF_ID_LOW, 32'h00000000);
    rom(Q_NAME, 32'h31333934);
    $display("test reset values done");
  endtask
  task automatic t_regs;
    bus(1'b1, OFF_HEADER, 32'hA5C3F00F);
    rom(Q_HEADER, 32'hA5C3F00F);
    be <= 4'h3;
    bus(1'b1, OFF_HEADER, 32'h00001234);
    be <= 4'hF;
    rd("header lanes", OFF_HEADER, 32'hA5C31234);
    bus(1'b1, OFF_NAME, 32'h00000000);
    rd("name", OFF_NAME, 32'h31333934);
    bus(1'b1, OFF_OPTIONS, 32'h07008F39);
    rd("options", OFF_OPTIONS, 32'h07008F39);
    rom(Q_OPTIONS, 32'h07008F39);
    bus(1'b1, OFF_OPTIONS, 32'h07008F79);
    rom(Q_OPTIONS, 32'h07008F79);
    bus(1'b0, 6'h3C, 32'h00000000);
    chk("unmapped", 32'h00000002, {30'h0, r});
    $display("test registers done");
  endtask
  task automatic t_pkt;
    pkt(1'b0, 16'h0010, 3'h2, 1'b1, 1'b0);
    pkt(1'b0, 16'h0010, 3'h1, 1'b0, 1'b0);
    pkt(1'b1, 16'h0200, 3'h1, 1'b0, 1'b0);
    pkt(1'b1, 16'h0201, 3'h0, 1'b0, 1'b1);
    pkt(1'b0, 16'h0400, 3'h0, 1'b0, 1'b0);
    $display("test packets done");
  endtask
  task automatic t_ident;
    bus(1'b1, OFF_ID_HIGH, 32'h12345678);
    bus(1'b1, OFF_ID_LOW, 32'h9ABCDEF0);
    rom(Q_ID_HIGH, 32'h12345678);
    rom(Q_ID_LOW, 32'h9ABCDEF0);
    bus(1'b1, OFF_ID_HIGH, 32'h11111111);
    bus(1'b1, OFF_ID_LOW, 32'h22222222);
    rd("id high", OFF_ID_HIGH, 32'h12345678);
    rd("id low", OFF_ID_LOW, 32'h9ABCDEF0);
    bus(1'b1, OFF_CONTROL, 32'h00000001);
    #1;
    chk("link", 32'h1, {31'h0, link_on});
    $display("test identity done");
  endtask
  task automatic t_soft;
    bus(1'b1, OFF_CONTROL, 32'h00000002);
    repeat (2) @(posedge clk);
    #1;
    chk("link", 32'h0, {31'h0, link_on});
    rd("id high", OFF_ID_HIGH, 32'h12345678);
    rd("header", OFF_HEADER, 32'hA5C31234);
    bus(1'b0, OFF_OPTIONS, 32'h00000000);
    chk("payload", 32'h8, {28'h0, d[15:12]});
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd("id low", OFF_ID_LOW, 32'h00000000);
    $display("test soft and hard reset done");
  endtask

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict;
  end
  initial begin
    {rst, read, write, start, pkt_check, pkt_bw} = 6'h20;
    {address, writedata, idx, pkt_speed, pkt_length} = '0;
    be = 4'hF;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_pkt;
    t_ident;
    t_soft;
    give_verdict;
  end
endmodule
